// File: core/hms_pkg.sv
/*
 * hms_pkg: shared types and constants of the measurement sequencer.
 * Assumes a 100 MHz system clock; all users write hms_pkg::name.
 */
`default_nettype none
package hms_pkg;
	localparam int          DATA_W        = 12;
	localparam int          FIFO_DEPTH    = 4;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          INT_PULSE_NS  = 2500;
	localparam int          INT_PULSE_CYC = INT_PULSE_NS / CLK_PERIOD_NS;
	localparam logic [8:0]  INT_CNT_LOAD  = 9'(INT_PULSE_CYC - 1);
	localparam logic [11:0] RESULT_RST    = 12'h000;

	typedef enum logic [1:0] {
		HMS_MODE_POWER_DOWN = 2'h0,
		HMS_MODE_LOW_POWER  = 2'h1,
		HMS_MODE_FAST       = 2'h2,
		HMS_MODE_MASTER     = 2'h3
	} hms_mode_e;

	typedef enum logic [1:0] {
		HMS_CFG_XYZT = 2'h0,
		HMS_CFG_XYZ  = 2'h1,
		HMS_CFG_XY   = 2'h2
	} hms_cfg_e;

	typedef enum logic [1:0] {
		HMS_CH_FIELD_AXIS_X = 2'h0,
		HMS_CH_FIELD_AXIS_Y = 2'h1,
		HMS_CH_FIELD_AXIS_Z = 2'h2,
		HMS_CH_TEMP         = 2'h3
	} hms_chan_e;

	typedef enum logic [2:0] {
		HMS_ST_IDLE  = 3'h0,
		HMS_ST_REQ   = 3'h1,
		HMS_ST_WAIT  = 3'h3,
		HMS_ST_STORE = 3'h2,
		HMS_ST_DONE  = 3'h6
	} hms_state_e;

	typedef struct packed {
		hms_chan_e         chan;
		logic [DATA_W-1:0] data;
	} hms_word_s;

	typedef struct packed {
		logic [DATA_W-1:0] field_axis_x;
		logic [DATA_W-1:0] field_axis_y;
		logic [DATA_W-1:0] field_axis_z;
		logic [DATA_W-1:0] temp;
	} hms_res_s;
endpackage
`default_nettype wire

// File: core/hms_fifo.sv
/*
 * hms_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none
module hms_fifo #(
	parameter int W     = 14,
	parameter int DEPTH = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] wr_ptr_nxt;
	logic [AW-1:0] rd_ptr_r;
	logic [AW-1:0] rd_ptr_nxt;
	logic [AW:0]   count_r;
	logic [AW:0]   count_nxt;
	logic          push;
	logic          pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
		rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
		count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end
endmodule
`default_nettype wire

// File: core/hms_seq.sv
/*
 * hms_seq: measurement cycle sequencer of a three-axis field sensor with
 * a temperature channel. Issues conversion requests, samples results from
 * the converter link, keeps latest results, queues them for the reader and
 * pulses the end-of-conversion line.
 * Assumes triggers come from clk_sys logic; the converter link (conv_clk,
 * conv_valid, conv_data) is asynchronous and is sampled here.
 */
// Notes on behaviour
// - In fast mode a new cycle starts at once when the previous one ends, without a trigger.
// - In low-power mode a cycle starts only on the internal trigger, in master mode only on the external one; power-down starts none.
// - With the four-channel setting a cycle ends after the temperature conversion.
// - With the three-channel setting temperature is skipped, kept, and the cycle ends after Z.
// - With the two-axis setting Z and temperature are skipped, kept, and the cycle ends after Y.
// - When enabled, each cycle end gives a low pulse of about 2.5 us (1.8 to 3.2 us) on int_n.
// - In master-controlled mode the controller's bus trigger starts each cycle.
`default_nettype none
module hms_seq (
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	input  wire hms_pkg::hms_mode_e            mode,
	input  wire hms_pkg::hms_cfg_e             chan_cfg,
	input  wire logic                          int_en,
	input  wire logic                          int_trig,
	input  wire logic                          ext_trig,
	input  wire logic                          conv_clk,
	input  wire logic                          conv_valid,
	input  wire logic [hms_pkg::DATA_W-1:0]    conv_data,
	output logic                               conv_req,
	output hms_pkg::hms_chan_e                 conv_chan,
	output logic                               int_n,
	output logic                               busy,
	output hms_pkg::hms_res_s                  results,
	output logic                               res_valid,
	input  wire logic                          res_ready,
	output hms_pkg::hms_word_s                 res_word
);
	hms_pkg::hms_state_e state_r;
	hms_pkg::hms_state_e state_nxt;
	hms_pkg::hms_chan_e  chan_r;
	hms_pkg::hms_chan_e  chan_nxt;
	hms_pkg::hms_res_s   res_r;
	hms_pkg::hms_res_s   res_nxt;
	hms_pkg::hms_word_s  cap_r;
	hms_pkg::hms_word_s  cap_nxt;
	hms_pkg::hms_word_s  out_r;
	hms_pkg::hms_word_s  out_nxt;
	logic                out_valid_r;
	logic                out_valid_nxt;
	logic                int_n_r;
	logic                int_n_nxt;
	logic [8:0]          int_cnt_r;
	logic [8:0]          int_cnt_nxt;
	logic                conv_req_r;
	logic                conv_req_nxt;
	logic                busy_r;
	logic                busy_nxt;

	// converter link sampling: stage 1 feeds stage 2 only
	logic                       lclk_meta_r;
	logic                       lclk_sync_r;
	logic                       lclk_prev_r;
	logic                       lval_meta_r;
	logic                       lval_sync_r;
	logic [hms_pkg::DATA_W-1:0] ldat_meta_r;
	logic [hms_pkg::DATA_W-1:0] ldat_sync_r;
	logic                       link_take;

	logic                       trig;
	logic                       start;
	logic                       fifo_in_ready;
	logic                       fifo_in_valid;
	logic                       fifo_out_valid;
	logic                       fifo_out_ready;
	hms_pkg::hms_word_s         fifo_out_data;

	function automatic hms_pkg::hms_chan_e last_chan(input hms_pkg::hms_cfg_e cfg);
		case (cfg)
			hms_pkg::HMS_CFG_XYZ: last_chan = hms_pkg::HMS_CH_FIELD_AXIS_Z;
			hms_pkg::HMS_CFG_XY:  last_chan = hms_pkg::HMS_CH_FIELD_AXIS_Y;
			default:              last_chan = hms_pkg::HMS_CH_TEMP;
		endcase
	endfunction

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lclk_meta_r <= 1'b0;
			lclk_sync_r <= 1'b0;
			lclk_prev_r <= 1'b0;
			lval_meta_r <= 1'b0;
			lval_sync_r <= 1'b0;
			ldat_meta_r <= '0;
			ldat_sync_r <= '0;
		end else begin
			lclk_meta_r <= conv_clk;
			lclk_sync_r <= lclk_meta_r;
			lclk_prev_r <= lclk_sync_r;
			lval_meta_r <= conv_valid;
			lval_sync_r <= lval_meta_r;
			ldat_meta_r <= conv_data;
			ldat_sync_r <= ldat_meta_r;
		end
	end

	assign link_take     = lclk_sync_r && !lclk_prev_r && lval_sync_r;
	assign trig          = (mode == hms_pkg::HMS_MODE_LOW_POWER) ? int_trig :
	                       (mode == hms_pkg::HMS_MODE_MASTER) ? ext_trig : 1'b0;
	assign start         = (mode == hms_pkg::HMS_MODE_FAST) || trig;
	assign fifo_in_valid = (state_r == hms_pkg::HMS_ST_STORE);

	// cycle sequencer
	always_comb begin
		state_nxt = state_r;
		chan_nxt  = chan_r;
		res_nxt   = res_r;
		cap_nxt   = cap_r;
		case (state_r)
			hms_pkg::HMS_ST_IDLE: begin
				if (start) begin
					state_nxt = hms_pkg::HMS_ST_REQ;
					chan_nxt  = hms_pkg::HMS_CH_FIELD_AXIS_X;
				end
			end
			hms_pkg::HMS_ST_REQ: begin
				state_nxt = hms_pkg::HMS_ST_WAIT;
			end
			hms_pkg::HMS_ST_WAIT: begin
				if (link_take) begin
					state_nxt = hms_pkg::HMS_ST_STORE;
					cap_nxt   = '{chan: chan_r, data: ldat_sync_r};
					case (chan_r)
						hms_pkg::HMS_CH_FIELD_AXIS_X: res_nxt.field_axis_x = ldat_sync_r;
						hms_pkg::HMS_CH_FIELD_AXIS_Y: res_nxt.field_axis_y = ldat_sync_r;
						hms_pkg::HMS_CH_FIELD_AXIS_Z: res_nxt.field_axis_z = ldat_sync_r;
						default:                      res_nxt.temp = ldat_sync_r;
					endcase
				end
			end
			hms_pkg::HMS_ST_STORE: begin
				// a full queue stalls the cycle here
				if (fifo_in_ready) begin
					if (chan_r == last_chan(chan_cfg)) begin
						state_nxt = hms_pkg::HMS_ST_DONE;
					end else begin
						state_nxt = hms_pkg::HMS_ST_REQ;
						chan_nxt  = hms_pkg::hms_chan_e'(chan_r + 2'h1);
					end
				end
			end
			hms_pkg::HMS_ST_DONE: begin
				if (mode == hms_pkg::HMS_MODE_FAST) begin
					state_nxt = hms_pkg::HMS_ST_REQ;
					chan_nxt  = hms_pkg::HMS_CH_FIELD_AXIS_X;
				end else begin
					state_nxt = hms_pkg::HMS_ST_IDLE;
				end
			end
			default: begin
				state_nxt = hms_pkg::HMS_ST_IDLE;
			end
		endcase
		conv_req_nxt = (state_nxt == hms_pkg::HMS_ST_REQ) || (state_nxt == hms_pkg::HMS_ST_WAIT);
		busy_nxt     = (state_nxt != hms_pkg::HMS_ST_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r    <= hms_pkg::HMS_ST_IDLE;
			chan_r     <= hms_pkg::HMS_CH_FIELD_AXIS_X;
			res_r      <= '{default: hms_pkg::RESULT_RST};
			cap_r      <= '0;
			conv_req_r <= 1'b0;
			busy_r     <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			chan_r     <= chan_nxt;
			res_r      <= res_nxt;
			cap_r      <= cap_nxt;
			conv_req_r <= conv_req_nxt;
			busy_r     <= busy_nxt;
		end
	end

	// end-of-conversion pulse; a retrigger restarts the pulse
	always_comb begin
		int_n_nxt   = int_n_r;
		int_cnt_nxt = int_cnt_r;
		if (state_r == hms_pkg::HMS_ST_DONE && int_en) begin
			int_n_nxt   = 1'b0;
			int_cnt_nxt = hms_pkg::INT_CNT_LOAD;
		end else if (!int_n_r) begin
			if (int_cnt_r == '0) begin
				int_n_nxt = 1'b1;
			end else begin
				int_cnt_nxt = int_cnt_r - 9'h001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			int_n_r   <= 1'b1;
			int_cnt_r <= '0;
		end else begin
			int_n_r   <= int_n_nxt;
			int_cnt_r <= int_cnt_nxt;
		end
	end

	hms_fifo #(
		.W     ($bits(hms_pkg::hms_word_s)),
		.DEPTH (hms_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (cap_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// registered output stage of the result queue
	assign fifo_out_ready = !out_valid_r || res_ready;

	always_comb begin
		out_valid_nxt = out_valid_r;
		out_nxt       = out_r;
		if (fifo_out_ready) begin
			out_valid_nxt = fifo_out_valid;
			if (fifo_out_valid) begin
				out_nxt = fifo_out_data;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			out_valid_r <= 1'b0;
			out_r       <= '0;
		end else begin
			out_valid_r <= out_valid_nxt;
			out_r       <= out_nxt;
		end
	end

	assign conv_req  = conv_req_r;
	assign conv_chan = chan_r;
	assign int_n     = int_n_r;
	assign busy      = busy_r;
	assign results   = res_r;
	assign res_valid = out_valid_r;
	assign res_word  = out_r;

	chk_fast_restart: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == hms_pkg::HMS_ST_DONE && mode == hms_pkg::HMS_MODE_FAST
		|=> state_r == hms_pkg::HMS_ST_REQ && chan_r == hms_pkg::HMS_CH_FIELD_AXIS_X)
		else $error("fast mode did not restart the cycle");
	chk_idle_no_trig: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == hms_pkg::HMS_ST_IDLE && mode != hms_pkg::HMS_MODE_FAST
		&& !int_trig && !ext_trig |=> state_r == hms_pkg::HMS_ST_IDLE)
		else $error("cycle started without a trigger");
	chk_end_temp: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == hms_pkg::HMS_ST_STORE && fifo_in_ready
		&& chan_cfg == hms_pkg::HMS_CFG_XYZT && chan_r == hms_pkg::HMS_CH_TEMP
		|=> state_r == hms_pkg::HMS_ST_DONE)
		else $error("four-channel cycle did not end after temperature");
	chk_skip_temp: assert property (@(posedge clk_sys) disable iff (rst)
		chan_cfg == hms_pkg::HMS_CFG_XYZ && $stable(chan_cfg) && conv_req
		|-> chan_r != hms_pkg::HMS_CH_TEMP && $stable(res_r.temp))
		else $error("temperature converted in three-channel setting");
	chk_skip_z_temp: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == hms_pkg::HMS_ST_STORE && fifo_in_ready
		&& chan_cfg == hms_pkg::HMS_CFG_XY && chan_r == hms_pkg::HMS_CH_FIELD_AXIS_Y
		|=> state_r == hms_pkg::HMS_ST_DONE ##1 $stable(res_r.field_axis_z))
		else $error("two-axis cycle did not end after Y");
	chk_int_width: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(int_n_r) |-> $past(int_n_r, 250) == 1'b0
		&& $past(state_r, 251) == hms_pkg::HMS_ST_DONE)
		else $error("end-of-conversion pulse width wrong");
	chk_master_trig: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == hms_pkg::HMS_ST_IDLE && mode == hms_pkg::HMS_MODE_MASTER && ext_trig
		|=> state_r == hms_pkg::HMS_ST_REQ ##1 conv_req)
		else $error("bus trigger did not start a cycle");
	chk_chan_order: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == hms_pkg::HMS_ST_STORE && fifo_in_ready && chan_r != last_chan(chan_cfg)
		|=> state_r == hms_pkg::HMS_ST_REQ && chan_r == $past(chan_r) + 2'h1)
		else $error("channel order broken");
endmodule
`default_nettype wire

// File: tb/hms_conv_model.sv
/*
 * hms_conv_model: behavioural converter at the far end of the result link.
 * Assumes conv_req/conv_chan from hms_seq; link clock runs only in frames.
 */
`default_nettype none
module hms_conv_model (
	input  wire logic                        conv_req,
	input  wire hms_pkg::hms_chan_e          conv_chan,
	input  wire logic                        slow,
	output logic                             conv_clk,
	output logic                             conv_valid,
	output logic [hms_pkg::DATA_W-1:0]       conv_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		conv_clk = 1'b0;
		conv_valid = 1'b0;
		conv_data = 12'hA5A;
		forever begin
			wait (conv_req === 1'b1);
			// slow answer delays the whole conversion
			if (slow) #2000;
			#62.5;
			// channel code in the top bits lets the bench pair words to channels
			conv_data = {conv_chan, 2'h0, cnt};
			conv_valid = 1'b1;
			#62.5 conv_clk = 1'b1;
			wait (conv_req === 1'b0);
			#62.5 conv_clk = 1'b0;
			conv_valid = 1'b0;
			// released data must not keep the last value
			conv_data = ~conv_data;
			cnt = cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: tb/hms_seq_tb_top.sv
/*
 * hms_seq_tb_top: self-checking bench of the measurement sequencer.
 * Assumes hms_pkg, hms_fifo, hms_seq and the converter model are compiled.
 */
`default_nettype none
module hms_seq_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                     clk_sys = 1'b0;
	logic                     rst = 1'b1;
	logic                     int_en = 1'b1;
	logic                     int_trig = 1'b0;
	logic                     ext_trig = 1'b0;
	logic                     res_ready = 1'b1;
	logic                     slow = 1'b0;
	hms_pkg::hms_mode_e       mode = hms_pkg::HMS_MODE_POWER_DOWN;
	hms_pkg::hms_cfg_e        chan_cfg = hms_pkg::HMS_CFG_XYZT;
	logic                     conv_clk;
	logic                     conv_valid;
	logic [11:0]              conv_data;
	logic                     conv_req;
	hms_pkg::hms_chan_e       conv_chan;
	logic                     int_n;
	logic                     busy;
	hms_pkg::hms_res_s        results;
	logic                     res_valid;
	hms_pkg::hms_word_s       res_word;
	hms_pkg::hms_word_s       q[$];
	int                       num_errors = 0;
	int                       num_checks = 0;
	int                       cyc = 0;

	hms_seq dut (.clk_sys(clk_sys), .rst(rst), .mode(mode), .chan_cfg(chan_cfg),
		.int_en(int_en), .int_trig(int_trig), .ext_trig(ext_trig), .conv_clk(conv_clk),
		.conv_valid(conv_valid), .conv_data(conv_data), .conv_req(conv_req),
		.conv_chan(conv_chan), .int_n(int_n), .busy(busy), .results(results),
		.res_valid(res_valid), .res_ready(res_ready), .res_word(res_word));

	hms_conv_model conv (.conv_req(conv_req), .conv_chan(conv_chan), .slow(slow),
		.conv_clk(conv_clk), .conv_valid(conv_valid), .conv_data(conv_data));

	always #5 clk_sys = ~clk_sys;

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// collects words leaving the queue; cuts a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (res_valid === 1'b1 && res_ready === 1'b1)
			q.push_back(res_word);
		if (cyc == 40000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic wait_idle();
		int t = 0;
		while (busy !== 1'b0 && t < 5000) begin
			step(1);
			t++;
		end
	endtask

	task automatic trig(input logic it, input logic et);
		int_trig = it;
		ext_trig = et;
		step(1);
		int_trig = 1'b0;
		ext_trig = 1'b0;
		step(3);
	endtask

	task automatic refuse();
		int n = 0;
		mode = hms_pkg::HMS_MODE_LOW_POWER;
		trig(1'b0, 1'b1);
		chk(busy === 1'b0 && conv_req === 1'b0, "bus trigger started low power");
		mode = hms_pkg::HMS_MODE_MASTER;
		trig(1'b1, 1'b0);
		chk(busy === 1'b0 && conv_req === 1'b0, "internal trigger started master");
		mode = hms_pkg::HMS_MODE_POWER_DOWN;
		trig(1'b1, 1'b1);
		chk(busy === 1'b0 && conv_req === 1'b0, "power down started");
		mode = hms_pkg::HMS_MODE_LOW_POWER;
		int_en = 1'b0;
		trig(1'b1, 1'b0);
		chk(busy === 1'b1, "internal trigger ignored");
		wait_idle();
		while (n < 300 && int_n === 1'b1) begin
			step(1);
			n++;
		end
		chk(n == 300, "pulse while disabled");
		int_en = 1'b1;
		$display("done refuse");
	endtask

	task automatic meas(input hms_pkg::hms_cfg_e cfg, input int n);
		hms_pkg::hms_res_s prev_res;
		int t = 0;
		chan_cfg = cfg;
		mode = hms_pkg::HMS_MODE_MASTER;
		prev_res = results;
		q.delete();
		// reader holds off until its first read window opens
		res_ready = 1'b0;
		ext_trig = 1'b1;
		step(1);
		ext_trig = 1'b0;
		chk(busy === 1'b1, "no start on bus trigger");
		wait_idle();
		while (int_n !== 1'b0 && t < 5) begin
			step(1);
			t++;
		end
		t = 0;
		while (int_n === 1'b0 && t < 400) begin
			step(1);
			t++;
		end
		chk(t == 250, "end pulse length");
		chk(q.size() == 0 && res_valid === 1'b1, "words not held");
		// 30 us after the rising edge of int_n
		step(3000);
		res_ready = 1'b1;
		step(10);
		chk(q.size() == n, "word count");
		for (int i = 0; i < q.size(); i++)
			chk(q[i].chan === hms_pkg::hms_chan_e'(i) && q[i].data[11:10] === 2'(i), "order");
		chk(results.field_axis_x === q[0].data, "x result");
		chk(results.field_axis_y === q[1].data, "y result");
		chk(results.field_axis_z === (n >= 3 ? q[2].data : prev_res.field_axis_z), "z result");
		chk(results.temp === (n == 4 ? q[3].data : prev_res.temp), "temp result");
		$display("done meas %0d", n);
	endtask

	task automatic fast_run();
		int n = 0;
		chan_cfg = hms_pkg::HMS_CFG_XY;
		res_ready = 1'b0;
		q.delete();
		mode = hms_pkg::HMS_MODE_FAST;
		step(1500);
		chk(busy === 1'b1 && conv_req === 1'b0 && res_valid === 1'b1, "no stall when full");
		while (n < 100 && conv_req === 1'b0) begin
			step(1);
			n++;
		end
		chk(n == 100, "request while full");
		res_ready = 1'b1;
		step(1500);
		mode = hms_pkg::HMS_MODE_POWER_DOWN;
		wait_idle();
		step(10);
		chk(q.size() > 10, "no free running restart");
		for (int i = 0; i < q.size(); i++)
			chk(q[i].chan === hms_pkg::hms_chan_e'(i % 2), "fast order");
		chk(res_valid === 1'b0, "queue not drained");
		$display("done fast_run");
	endtask

	initial begin
		step(20);
		rst = 1'b0;
		step(3);
		chk(busy === 1'b0 && int_n === 1'b1 && res_valid === 1'b0 && results === '0, "reset");
		refuse();
		meas(hms_pkg::HMS_CFG_XYZT, 4);
		meas(hms_pkg::HMS_CFG_XYZ, 3);
		meas(hms_pkg::HMS_CFG_XY, 2);
		slow = 1'b1;
		meas(hms_pkg::HMS_CFG_XYZT, 4);
		slow = 1'b0;
		fast_run();
		finish_test();
	end
endmodule
`default_nettype wire
